/* File: verilog/irq_status_pkg.sv */
package irq_status_pkg;

   // =========================================================
   // Register map (byte addresses on APB).
   // =========================================================
   // The status registers sit at word indices; each holds one aligned
   // 32-bit word, so its byte address is four times its index.
   localparam logic [9:0]  IDX_TRIG_SEL   = 10'h00A;
   localparam logic [9:0]  IDX_MODE_STAT  = 10'h00B;
   localparam logic [9:0]  IDX_SRC_FLAGS  = 10'h00C;
   localparam logic [11:0] ADDR_TRIG_SEL  = {IDX_TRIG_SEL, 2'h0};
   localparam logic [11:0] ADDR_MODE_STAT = {IDX_MODE_STAT, 2'h0};
   localparam logic [11:0] ADDR_SRC_FLAGS = {IDX_SRC_FLAGS, 2'h0};
   localparam logic [11:0] ADDR_CTRL      = 12'h010;
   localparam logic [11:0] ADDR_CLEAR     = 12'h014;

   // =========================================================
   // Field positions and reset values.
   // =========================================================
   localparam int TRIG_TRANS_BIT   = 5;
   localparam int TRIG_ORIENT_BIT  = 4;
   localparam int TRIG_PULSE_BIT   = 3;
   localparam int TRIG_FFMT_BIT    = 2;
   localparam int TRIG_VECM_BIT    = 1;
   localparam int SRC_ASLP_BIT     = 7;
   localparam int SRC_FIFO_BIT     = 6;
   localparam int SRC_TRANS_BIT    = 5;
   localparam int SRC_ORIENT_BIT   = 4;
   localparam int SRC_PULSE_BIT    = 3;
   localparam int SRC_FFMT_BIT     = 2;
   localparam int SRC_VECM_BIT     = 1;
   localparam int SRC_DRDY_BIT     = 0;
   localparam int GERR_BIT         = 7;
   localparam int GTIME_LSB        = 2;
   localparam int CTRL_ACTIVE_BIT  = 0;
   localparam int CLR_DRDY_BIT     = 0;
   localparam int CLR_FIFO_BIT     = 1;
   localparam int CLR_TRANS_BIT    = 2;
   localparam int CLR_ORIENT_BIT   = 3;
   localparam int CLR_PULSE_BIT    = 4;
   localparam int CLR_FFMT_BIT     = 5;
   localparam logic [7:0] TRIG_RESET  = 8'h00;
   localparam logic [7:0] SRC_RESET   = 8'h00;
   localparam logic [4:0] GTIME_MAX   = 5'h1F;
   localparam logic [15:0] SLEEP_LIM_RESET = 16'h0010;

   // Mode codes as reported to software.
   localparam logic [1:0] MODE_STANDBY = 2'h0;
   localparam logic [1:0] MODE_WAKE    = 2'h1;
   localparam logic [1:0] MODE_SLEEP   = 2'h2;

   // Events from the detection engines, one pulse per event.
   typedef struct packed {
      logic drdy;
      logic vecm;
      logic ffmt;
      logic pulse;
      logic orient;
      logic trans;
      logic fifo_ovf;
      logic fifo_wmrk;
      logic gate_err;
      logic odr_tick;
      logic activity;
      logic wake_evt;
   } event_s;

   // Clear strobes from reads of the function source registers.
   typedef struct packed {
      logic drdy;
      logic fifo;
      logic trans;
      logic orient;
      logic pulse;
      logic ffmt;
   } clear_s;

endpackage

/* File: verilog/sticky_flag.sv */
`timescale 1ns/1ps
// =========================================================
// Sticky flag: a set in the same cycle as a clear wins.
// =========================================================
module sticky_flag (
   input  wire logic ref_clk,  // Sample clock.
   input  wire logic sys_rst,  // Asynchronous reset, active high.
   input  wire logic set,      // Event pulse.
   input  wire logic clear,    // Clear strobe.
   output logic      flag      // Held flag.
);
   logic next_flag;  // Next flag value.

   // Set has priority so a coincident event is never lost.
   always_comb begin
      next_flag = set | (flag & ~clear);
   end

   // Register the flag.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag <= 1'b0;
      end else begin
         flag <= next_flag;
      end
   end

   // A coincident set and clear must leave the flag high.
   a_set_wins_clear: assert property (
      @(posedge ref_clk) disable iff (sys_rst) set |=> flag)
      else $error("Flag lost an event on coincident clear.");
endmodule

/* File: verilog/irq_status.sv */
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// =========================================================
// Interrupt source, operating mode and FIFO trigger status.
// =========================================================
module irq_status (
   input  wire logic                    ref_clk,     // Sample clock, 100 MHz.
   input  wire logic                    sys_rst,     // Asynchronous reset.
   input  wire logic                    psel,        // APB select.
   input  wire logic                    penable,     // APB access phase.
   input  wire logic                    pwrite,      // APB direction.
   input  wire logic [11:0]             paddr,       // APB byte address.
   input  wire logic [31:0]             pwdata,      // APB write data.
   output logic      [31:0]             prdata,      // APB read data.
   output logic                         pready,      // APB ready.
   output logic                         pslverr,     // APB error.
   input  wire irq_status_pkg::event_s  evt,         // Engine events.
   input  wire irq_status_pkg::clear_s  src_clr,     // Source-read clears.
   input  wire logic                    fifo_empty,  // FIFO buffer empty.
   output logic                         fifo_gate,   // Stop FIFO collection.
   output logic                         low_odr_sel  // Sleep rate selected.
);

   // =========================================================
   // Declarations.
   // =========================================================
   typedef enum logic [2:0] {
      ST_STANDBY = 3'b001,
      ST_WAKE    = 3'b010,
      ST_SLEEP   = 3'b100
   } mode_e;

   mode_e        mode;             // Operating mode.
   mode_e        next_mode;        // Next operating mode.
   logic [7:0]   trig_sel;         // FIFO trigger enables.
   logic [7:0]   next_trig_sel;    // Next trigger enables.
   logic         active;           // Software active request.
   logic         next_active;      // Next active request.
   logic [15:0]  sleep_lim;        // Inactivity limit in ODR ticks.
   logic [15:0]  next_sleep_lim;   // Next limit.
   logic [15:0]  idle_cnt;         // Inactivity counter.
   logic [15:0]  next_idle_cnt;    // Next inactivity counter.
   logic         gerr;             // Gate error flag.
   logic         next_gerr;        // Next gate error flag.
   logic [4:0]   gtime;            // ODR ticks since gate error.
   logic [4:0]   next_gtime;       // Next gate error time.
   logic         gate;             // Collection gated.
   logic         next_gate;        // Next gate state.
   logic [31:0]  next_prdata;      // Next read data.
   logic [7:0]   src;              // Interrupt source flags.
   logic [7:0]   set_vec;          // Per-flag set pulses.
   logic [7:0]   clr_vec;          // Per-flag clear strobes.
   logic         wr_en;            // APB write in access phase.
   logic         rd_en;            // APB read in access phase.
   logic         aslp_evt;         // Wake to sleep or sleep to wake transition event.
   logic         trig_hit;         // Enabled trigger event.

   // Decode a byte address against a register offset.
   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   // =========================================================
   // APB slave: zero wait states, unmapped reads return zero.
   // =========================================================
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // =========================================================
   // Flag set and clear vectors.
   // =========================================================
   // Each source bit is set by its engine event (the FIFO bit by overflow or watermark, the auto-sleep bit by a wake to sleep or sleep to wake
   // transition) and cleared by the read of the register that belongs to that function.
   always_comb begin
      set_vec = 8'h00;
      clr_vec = 8'h00;
      set_vec[irq_status_pkg::SRC_ASLP_BIT]   = aslp_evt;
      set_vec[irq_status_pkg::SRC_FIFO_BIT]   = evt.fifo_ovf | evt.fifo_wmrk;
      set_vec[irq_status_pkg::SRC_TRANS_BIT]  = evt.trans;
      set_vec[irq_status_pkg::SRC_ORIENT_BIT] = evt.orient;
      set_vec[irq_status_pkg::SRC_PULSE_BIT]  = evt.pulse;
      set_vec[irq_status_pkg::SRC_FFMT_BIT]   = evt.ffmt;
      set_vec[irq_status_pkg::SRC_VECM_BIT]   = evt.vecm;
      set_vec[irq_status_pkg::SRC_DRDY_BIT]   = evt.drdy;
      // Mode register read clears the auto-sleep flag.
      clr_vec[irq_status_pkg::SRC_ASLP_BIT]   =
         rd_en & hit(paddr, irq_status_pkg::ADDR_MODE_STAT);
      clr_vec[irq_status_pkg::SRC_FIFO_BIT]   = src_clr.fifo;
      clr_vec[irq_status_pkg::SRC_TRANS_BIT]  = src_clr.trans;
      clr_vec[irq_status_pkg::SRC_ORIENT_BIT] = src_clr.orient;
      clr_vec[irq_status_pkg::SRC_PULSE_BIT]  = src_clr.pulse;
      clr_vec[irq_status_pkg::SRC_FFMT_BIT]   = src_clr.ffmt;
      // Only the vector-magnitude flag clears on a source read.
      clr_vec[irq_status_pkg::SRC_VECM_BIT]   =
         rd_en & hit(paddr, irq_status_pkg::ADDR_SRC_FLAGS);
      clr_vec[irq_status_pkg::SRC_DRDY_BIT]   = src_clr.drdy;
   end

   // One sticky flag per source bit.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         sticky_flag u_flag (
            .ref_clk (ref_clk),
            .sys_rst (sys_rst),
            .set     (set_vec[gi]),
            .clear   (clr_vec[gi]),
            .flag    (src[gi])
         );
      end
   endgenerate

   // =========================================================
   // Operating mode and auto-sleep.
   // =========================================================
   // The idle counter counts ODR ticks without activity while awake.
   always_comb begin
      next_mode     = mode;
      next_idle_cnt = idle_cnt;
      aslp_evt      = 1'b0;
      unique case (mode)
         ST_STANDBY: begin
            next_idle_cnt = 16'h0000;
            if (active) begin
               next_mode = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (!active) begin
               next_mode = ST_STANDBY;
            end else if (evt.activity) begin
               next_idle_cnt = 16'h0000;
            end else if (evt.odr_tick) begin
               if (idle_cnt >= sleep_lim) begin
                  next_mode     = ST_SLEEP;
                  next_idle_cnt = 16'h0000;
                  aslp_evt      = 1'b1;
               end else begin
                  next_idle_cnt = idle_cnt + 16'h0001;
               end
            end
         end
         ST_SLEEP: begin
            if (!active) begin
               next_mode = ST_STANDBY;
            end else if (evt.wake_evt) begin
               next_mode = ST_WAKE;
               aslp_evt  = 1'b1;
            end
         end
      endcase
   end

   // Register mode state.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode     <= ST_STANDBY;
         idle_cnt <= 16'h0000;
      end else begin
         mode     <= next_mode;
         idle_cnt <= next_idle_cnt;
      end
   end

   assign low_odr_sel = (mode == ST_SLEEP);

   // =========================================================
   // FIFO trigger and gate error.
   // =========================================================
   // A trigger fires only from events whose enable bit is set.
   always_comb begin
      trig_hit = (trig_sel[irq_status_pkg::TRIG_PULSE_BIT] & evt.pulse)
               | (trig_sel[irq_status_pkg::TRIG_FFMT_BIT]  & evt.ffmt)
               | (trig_sel[irq_status_pkg::TRIG_VECM_BIT]  & evt.vecm)
               | (trig_sel[irq_status_pkg::TRIG_TRANS_BIT] & evt.trans)
               | (trig_sel[irq_status_pkg::TRIG_ORIENT_BIT] & evt.orient);
   end

   // The gate holds until the FIFO is drained, so the pre-event
   // samples are kept. Gate error set beats the empty clear.
   always_comb begin
      next_gate  = trig_hit | (gate & ~fifo_empty);
      next_gerr  = evt.gate_err | (gerr & ~fifo_empty);
      next_gtime = gtime;
      if (!next_gerr) begin
         next_gtime = 5'h00;
      end else if (gerr && evt.odr_tick && gtime != irq_status_pkg::GTIME_MAX) begin
         next_gtime = gtime + 5'h01;
      end
   end

   // Register gate state.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gate  <= 1'b0;
         gerr  <= 1'b0;
         gtime <= 5'h00;
      end else begin
         gate  <= next_gate;
         gerr  <= next_gerr;
         gtime <= next_gtime;
      end
   end

   assign fifo_gate = gate;

   // =========================================================
   // Software-written registers.
   // =========================================================
   always_comb begin
      next_trig_sel  = trig_sel;
      next_active    = active;
      next_sleep_lim = sleep_lim;
      if (wr_en && hit(paddr, irq_status_pkg::ADDR_TRIG_SEL)) begin
         next_trig_sel = pwdata[7:0];
      end
      if (wr_en && hit(paddr, irq_status_pkg::ADDR_CTRL)) begin
         next_active    = pwdata[irq_status_pkg::CTRL_ACTIVE_BIT];
         next_sleep_lim = pwdata[31:16];
      end
   end

   // Register control state.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         trig_sel  <= irq_status_pkg::TRIG_RESET;
         active    <= 1'b0;
         sleep_lim <= irq_status_pkg::SLEEP_LIM_RESET;
      end else begin
         trig_sel  <= next_trig_sel;
         active    <= next_active;
         sleep_lim <= next_sleep_lim;
      end
   end

   // =========================================================
   // Read data, registered in the setup phase.
   // =========================================================
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         if (hit(paddr, irq_status_pkg::ADDR_TRIG_SEL)) begin
            next_prdata[7:0] = trig_sel;
         end else if (hit(paddr, irq_status_pkg::ADDR_MODE_STAT)) begin
            next_prdata[irq_status_pkg::GERR_BIT] = gerr;
            next_prdata[irq_status_pkg::GTIME_LSB +: 5] = gtime;
            unique case (mode)
               ST_STANDBY: next_prdata[1:0] = irq_status_pkg::MODE_STANDBY;
               ST_WAKE:    next_prdata[1:0] = irq_status_pkg::MODE_WAKE;
               ST_SLEEP:   next_prdata[1:0] = irq_status_pkg::MODE_SLEEP;
            endcase
         end else if (hit(paddr, irq_status_pkg::ADDR_SRC_FLAGS)) begin
            next_prdata[7:0] = src;
         end else if (hit(paddr, irq_status_pkg::ADDR_CTRL)) begin
            next_prdata[irq_status_pkg::CTRL_ACTIVE_BIT] = active;
            next_prdata[31:16] = sleep_lim;
         end
      end else if (psel && penable) begin
         next_prdata = prdata;
      end
   end

   // Register read data.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= next_prdata;
      end
   end

   // =========================================================
   // Checks.
   // =========================================================
   a_pulse_trigger: assert property (@(posedge ref_clk) disable iff (sys_rst)
      evt.pulse && trig_sel[irq_status_pkg::TRIG_PULSE_BIT] |=> fifo_gate)
      else $error("Enabled pulse event did not gate the FIFO.");
   a_ffmt_trigger: assert property (@(posedge ref_clk) disable iff (sys_rst)
      evt.ffmt && trig_sel[irq_status_pkg::TRIG_FFMT_BIT] |=> fifo_gate)
      else $error("Enabled motion event did not gate the FIFO.");
   a_vecm_trigger: assert property (@(posedge ref_clk) disable iff (sys_rst)
      evt.vecm && trig_sel[irq_status_pkg::TRIG_VECM_BIT] |=> fifo_gate)
      else $error("Enabled vector event did not gate the FIFO.");
   // Written from the raw events and enables, not from trig_hit, so a
   // broken enable decode cannot hide behind its own expression.
   a_no_trigger: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !fifo_gate
      && !(evt.pulse && trig_sel[irq_status_pkg::TRIG_PULSE_BIT])
      && !(evt.ffmt && trig_sel[irq_status_pkg::TRIG_FFMT_BIT])
      && !(evt.vecm && trig_sel[irq_status_pkg::TRIG_VECM_BIT])
      && !(evt.trans && trig_sel[irq_status_pkg::TRIG_TRANS_BIT])
      && !(evt.orient && trig_sel[irq_status_pkg::TRIG_ORIENT_BIT])
      |=> !fifo_gate)
      else $error("FIFO gated without an enabled trigger.");
   a_gerr_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      gerr && !fifo_empty |=> gerr)
      else $error("Gate error flag cleared while FIFO not empty.");
   a_gtime_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !gerr |-> gtime == 5'h00)
      else $error("Gate error time nonzero without flag.");
   a_vecm_read_clr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_en && hit(paddr, irq_status_pkg::ADDR_SRC_FLAGS) && !evt.vecm
      |=> !src[irq_status_pkg::SRC_VECM_BIT])
      else $error("Source read did not clear the vector flag.");
   a_src_read_keep: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_en && hit(paddr, irq_status_pkg::ADDR_SRC_FLAGS) && src[irq_status_pkg::SRC_DRDY_BIT]
      && !src_clr.drdy |=> src[irq_status_pkg::SRC_DRDY_BIT])
      else $error("Source read cleared the data-ready flag.");
   a_sleep_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
      mode == ST_WAKE && active && evt.odr_tick && !evt.activity && idle_cnt >= sleep_lim
      |=> mode == ST_SLEEP ##0 src[irq_status_pkg::SRC_ASLP_BIT])
      else $error("Missed the wake to sleep transition.");
   a_wake_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
      mode == ST_SLEEP && active && evt.wake_evt |=> mode == ST_WAKE)
      else $error("Missed the sleep to wake transition.");
   a_fifo_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
      evt.fifo_ovf |=> src[irq_status_pkg::SRC_FIFO_BIT])
      else $error("FIFO overflow did not set its flag.");
endmodule

/* File: dv/apb_host.sv */
`timescale 1ns/1ps
// =========================================================
// Host processor model: APB master with bounded waits.
// =========================================================
module apb_host (
   input  wire logic        ref_clk,  // Sample clock.
   output logic             psel,     // Select.
   output logic             penable,  // Access phase.
   output logic             pwrite,   // Direction.
   output logic      [11:0] paddr,    // Byte address.
   output logic      [31:0] pwdata,   // Write data.
   input  wire logic [31:0] prdata,   // Read data.
   input  wire logic        pready    // Ready.
);
   int stalls = 0;  // Transfers whose answer never came.

   // Idle bus at time zero.
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // One transfer: held until pready is seen high or 50 cycles pass, then released.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         stalls++;
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released data lines must not keep the last value.
      pwdata <= ~wd;
   endtask
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
// =========================================================
// Self-checking bench for the status and source block.
// =========================================================
module testbench;
   logic                   ref_clk;      // Sample clock.
   logic                   sys_rst;      // Reset, active high.
   logic                   psel;         // APB select.
   logic                   penable;      // APB enable.
   logic                   pwrite;       // APB direction.
   logic [11:0]            paddr;        // APB address.
   logic [31:0]            pwdata;       // APB write data.
   logic [31:0]            prdata;       // APB read data.
   logic                   pready;       // APB ready.
   logic                   pslverr;      // APB error.
   irq_status_pkg::event_s evt;          // Engine events.
   irq_status_pkg::clear_s src_clr;      // Clear strobes.
   logic                   fifo_empty;   // FIFO empty level.
   logic                   fifo_gate;    // Collection stop.
   logic                   low_odr_sel;  // Sleep rate.
   int                     miscompares;  // Mismatch count.
   int                     n_checks;     // Comparison count.
   int                     exp;          // Modelled source flags.
   int                     n;            // Random tick count.
   logic [31:0]            xs;           // Random state.
   logic [31:0]            rd;           // Last read word.
   logic [7:0]             m;            // Trigger mask.

   irq_status dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .evt(evt), .src_clr(src_clr), .fifo_empty(fifo_empty),
      .fifo_gate(fifo_gate), .low_odr_sel(low_odr_sel));
   apb_host host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

   // Free-running 100 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // =========================================================
   // Shared tasks.
   // =========================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         miscompares++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Xorshift keeps the run repeatable.
   function automatic logic [31:0] rnd();
      xs ^= xs << 13;
      xs ^= xs >> 17;
      xs ^= xs << 5;
      return xs;
   endfunction

   // Events and clears last one cycle, as the engines send them.
   task automatic pulse_evt(input irq_status_pkg::event_s e, input irq_status_pkg::clear_s c);
      @(posedge ref_clk);
      evt <= e;
      src_clr <= c;
      @(posedge ref_clk);
      evt <= '0;
      src_clr <= '0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      host.xfer(1'b0, a, 32'h0, rd);
      check(rd, e);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rd);
   endtask

   task automatic empty_pulse();
      @(posedge ref_clk);
      fifo_empty <= 1'b1;
      @(posedge ref_clk);
      fifo_empty <= 1'b0;
   endtask

   // A hang ends the run as a failure.
   initial begin
      #400000;
      miscompares++;
      conclude();
   end

   // =========================================================
   // Main sequence.
   // =========================================================
   initial begin
      sys_rst = 1'b1;
      evt = '0;
      src_clr = '0;
      fifo_empty = 1'b0;
      miscompares = 0;
      n_checks = 0;
      xs = 32'h0000_EB7D;  // Seed 60285.
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd_chk(irq_status_pkg::ADDR_TRIG_SEL, 32'h0);
      rd_chk(irq_status_pkg::ADDR_MODE_STAT, 32'h0);
      rd_chk(irq_status_pkg::ADDR_SRC_FLAGS, 32'h0);
      rd_chk(12'h020, 32'h0);
      $display("Test reset done");
      // Engine events drdy to fifo_ovf each raise their own bit; a source read drops only bit 1.
      exp = 0;
      for (int k = 0; k < 7; k++) begin
         pulse_evt(irq_status_pkg::event_s'(12'h800 >> k), '0);
         exp |= 1 << k;
         rd_chk(irq_status_pkg::ADDR_SRC_FLAGS, exp);
         exp &= ~32'h2;
      end
      rd_chk(irq_status_pkg::ADDR_SRC_FLAGS, exp);
      for (int j = 0; j < 6; j++) begin
         pulse_evt('0, irq_status_pkg::clear_s'(6'h01 << j));
         exp &= ~(1 << ((j == 5) ? 0 : j + 2));
         rd_chk(irq_status_pkg::ADDR_SRC_FLAGS, exp);
      end
      pulse_evt(irq_status_pkg::event_s'(12'h100), irq_status_pkg::clear_s'(6'h02));
      rd_chk(irq_status_pkg::ADDR_SRC_FLAGS, 32'h8);
      pulse_evt('0, irq_status_pkg::clear_s'(6'h02));
      rd_chk(irq_status_pkg::ADDR_SRC_FLAGS, 32'h0);
      $display("Test sources done");
      // Random trigger mask over vecm, ffmt and pulse, then its complement,
      // so every enable is seen both set and clear.
      m = 8'(rnd()) & 8'h0E;
      for (int p = 0; p < 2; p++) begin
         wr(irq_status_pkg::ADDR_TRIG_SEL, 32'(m));
         rd_chk(irq_status_pkg::ADDR_TRIG_SEL, 32'(m));
         for (int k = 1; k < 4; k++) begin
            pulse_evt(irq_status_pkg::event_s'(12'h800 >> k), '0);
            #1;
            check(32'(fifo_gate), 32'(m[k]));
            empty_pulse();
            #1;
            check(32'(fifo_gate), 32'h0);
         end
         m ^= 8'h0E;
      end
      pulse_evt('0, '1);
      rd_chk(irq_status_pkg::ADDR_SRC_FLAGS, 32'h2);
      rd_chk(irq_status_pkg::ADDR_SRC_FLAGS, 32'h0);
      $display("Test trigger done");
      // Wake with a sleep limit of two idle ticks.
      wr(irq_status_pkg::ADDR_CTRL, 32'h0002_0001);
      rd_chk(irq_status_pkg::ADDR_MODE_STAT, 32'h1);
      repeat (2) pulse_evt(irq_status_pkg::event_s'(12'h004), '0);
      rd_chk(irq_status_pkg::ADDR_MODE_STAT, 32'h1);
      pulse_evt(irq_status_pkg::event_s'(12'h004), '0);
      rd_chk(irq_status_pkg::ADDR_SRC_FLAGS, 32'h80);
      check(32'(low_odr_sel), 32'h1);
      rd_chk(irq_status_pkg::ADDR_MODE_STAT, 32'h2);
      rd_chk(irq_status_pkg::ADDR_SRC_FLAGS, 32'h0);
      pulse_evt(irq_status_pkg::event_s'(12'h001), '0);
      rd_chk(irq_status_pkg::ADDR_SRC_FLAGS, 32'h80);
      rd_chk(irq_status_pkg::ADDR_MODE_STAT, 32'h1);
      check(32'(low_odr_sel), 32'h0);
      wr(irq_status_pkg::ADDR_CTRL, 32'h0);
      rd_chk(irq_status_pkg::ADDR_MODE_STAT, 32'h0);
      $display("Test mode done");
      // Gate error, then a random number of elapsed rate ticks.
      n = (rnd() % 7) + 1;
      pulse_evt(irq_status_pkg::event_s'(12'h008), '0);
      repeat (n) pulse_evt(irq_status_pkg::event_s'(12'h004), '0);
      rd_chk(irq_status_pkg::ADDR_MODE_STAT, 32'h80 | (n << 2));
      empty_pulse();
      rd_chk(irq_status_pkg::ADDR_MODE_STAT, 32'h0);
      $display("Test gate error done");
      check(32'(host.stalls), 32'h0);
      check(32'(pready), 32'h1);
      check(32'(pslverr), 32'h0);
      conclude();
   end
endmodule
